// ==== hw/sscp_pkg.sv ====
// constants and types shared by the serial command port
`default_nettype none
package sscp_pkg;
  // core clock rate
  localparam int CLK_MHZ = 100;
  // command codes
  localparam logic [7:0] CMD_STATUS = 8'h80;
  localparam logic [7:0] CMD_TEMP = 8'hC2;
  localparam logic [7:0] CMD_PFILT = 8'hC4;
  localparam logic [7:0] CMD_PRAW = 8'hC0;
  localparam logic [7:0] CMD_COEF_WR = 8'hE4;
  localparam logic [7:0] CMD_WAKE = 8'hA4;
  localparam logic [7:0] CMD_SHUTDOWN = 8'hA0;
  localparam logic [7:0] CMD_START = 8'hA8;
  localparam logic [7:0] CMD_STOP = 8'hAC;
  localparam logic [7:0] COEF_ADDR = 8'h6F;
  // answer bytes
  localparam logic [7:0] ACK_BYTE = 8'h00;
  localparam logic [7:0] NEGATIVE_ACKNOWLEDGE_BYTE = 8'hFF;
  localparam logic [7:0] BUSY_BYTE = 8'h00;
  localparam logic [7:0] DONE_BYTE = 8'h01;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  // status bytes
  localparam logic [7:0] STAT_SHUT = 8'h00;
  localparam logic [7:0] STAT_IDLE = 8'hE5;
  localparam logic [7:0] STAT_ACTIVE = 8'hED;
  // positions inside a frame
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BYTE_CMD = 3'h0;
  localparam logic [2:0] BYTE_ACK = 3'h1;
  localparam logic [2:0] BYTE_D0 = 3'h2;
  localparam logic [2:0] BYTE_D1 = 3'h3;
  localparam logic [2:0] BYTE_D2 = 3'h4;
  localparam logic [2:0] BYTE_D3 = 3'h5;
  localparam logic [2:0] BYTE_POLL = 3'h6;
  localparam logic [2:0] BYTE_MAX = 3'h7;
  // low-pass filter
  localparam logic [31:0] COEF_DEFAULT = 32'h0000_0000;
  localparam logic [31:0] COEF_ONE = 32'h0800_0000;
  localparam int COEF_FRAC = 27;
  localparam int RES_W = 24;
  localparam logic [8:0] PRES_PER_TEMP = 9'h100;
  // coefficient store time
  localparam int STORE_TIME_US = 15000;
  localparam int STORE_CYCLES = STORE_TIME_US * CLK_MHZ;
  typedef enum logic [1:0] {DEV_SHUT, DEV_IDLE, DEV_ACTIVE} sscp_dev_t;
  typedef struct packed {
    logic [7:0] status;
    logic [RES_W-1:0] praw;
    logic [RES_W-1:0] pfilt;
    logic [RES_W-1:0] temp;
  } sscp_res_t;
  typedef struct packed {
    logic start;
    logic temp;
  } sscp_conv_t;
  typedef struct packed {
    logic cmd_valid;
    logic [7:0] cmd;
    logic wr_valid;
    logic [31:0] coef;
  } sscp_req_t;
endpackage
`default_nettype wire

// ==== hw/sscp_sync.sv ====
// two-flop level synchroniser
`default_nettype none
module sscp_sync #(
  parameter int W = 1
) (
  // receiving domain
  input wire logic clk,
  input wire logic srst,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sscp_sync_t;
  sscp_sync_t st_q;
  sscp_sync_t st_d;

  always_comb begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule
`default_nettype wire

// ==== hw/sscp_top.sv ====
// serial command port of the pressure sensor with measurement sequencing
`default_nettype none
// What this block does
// - Coefficient write 0xE4 accepted only while idle; host also issues it in shutdown and active.
// - Command 0xC4 returns the low-pass filtered pressure result.
// - Entering shutdown restores the default filter coefficient.
// - Four-byte coefficient sets cutoff: 2^27 times exp(-2 pi fc conversion_time).
// - One temperature conversion after every 256 pressure conversions, longer.
// - Serial port active when interface select is high, else control and write requests are dropped and output stays released.
// - Mode 3: data changes on falling clock, sampled on rising clock.
// - Write format: one command byte in, one acknowledge byte out.
// - Write/read format: after acknowledge, result shifts out MSB first.
// - Store busy at most 15 ms; output 00h while busy, 01h when done.
// - Accepted command answered with eight low bits.
// - Invalid or refused command answered with eight high bits.
// - Serial output driven only while select is low, released after.
// - Results are 24 bits, MSB first, two's complement.
module sscp_top #(
  parameter int unsigned STORE_CYCLES = sscp_pkg::STORE_CYCLES
) (
  // core clock and reset
  input wire logic clk,
  input wire logic srst,
  // serial link
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // port selection pin
  input wire logic iface_sel,
  // measurement core
  output sscp_pkg::sscp_conv_t conv_req,
  input wire logic conv_done,
  input wire logic [sscp_pkg::RES_W-1:0] conv_data,
  output logic corr_update
);
  //////////////////////////////////////////////////////////////////////////
  // types and state

  typedef struct packed {
    logic [2:0] bit_idx;
    logic [2:0] byte_idx;
    logic [7:0] rx;
    logic ack_ok;
    logic addr_ok;
    logic [7:0] tx;
    logic [sscp_pkg::RES_W-1:0] word;
    sscp_pkg::sscp_req_t req;
  } sscp_link_t;

  typedef struct packed {
    logic sdo;
    logic oe;
  } sscp_out_t;

  typedef struct packed {
    sscp_pkg::sscp_dev_t dev;
    sscp_pkg::sscp_res_t res;
    sscp_pkg::sscp_res_t pub;
    logic [31:0] coef;
    logic [31:0] pend;
    logic busy;
    logic done;
    logic [31:0] timer;
    logic [8:0] pcnt;
    logic waiting;
    sscp_pkg::sscp_conv_t conv;
    logic corr_upd;
    logic cmd_seen;
    logic wr_seen;
  } sscp_core_t;

  sscp_link_t lk_q;
  sscp_link_t lk_d;
  sscp_out_t out_q;
  sscp_core_t co_q;
  sscp_core_t co_d;
  logic [7:0] rx_n;
  logic frm_s;
  logic cv_s;
  logic wv_s;
  logic done_s;
  logic sel_s;
  logic cmd_rise;
  logic wr_rise;
  logic signed [sscp_pkg::RES_W:0] diff;
  logic [27:0] kf;
  logic signed [53:0] prod;
  logic [sscp_pkg::RES_W-1:0] filt_n;

  //////////////////////////////////////////////////////////////////////////
  // decoding

  function automatic logic is_ctrl(input logic [7:0] c);
    return (c == sscp_pkg::CMD_WAKE) || (c == sscp_pkg::CMD_SHUTDOWN) ||
      (c == sscp_pkg::CMD_START) || (c == sscp_pkg::CMD_STOP);
  endfunction

  function automatic logic is_read(input logic [7:0] c);
    return (c == sscp_pkg::CMD_STATUS) || (c == sscp_pkg::CMD_TEMP) ||
      (c == sscp_pkg::CMD_PFILT) || (c == sscp_pkg::CMD_PRAW);
  endfunction

  function automatic logic cmd_ok(input logic [7:0] c, input logic [7:0] st);
    return is_ctrl(c) || is_read(c) ||
      ((c == sscp_pkg::CMD_COEF_WR) && (st == sscp_pkg::STAT_IDLE));
  endfunction

  function automatic logic [sscp_pkg::RES_W-1:0] pick(
    input logic [7:0] c,
    input sscp_pkg::sscp_res_t r
  );
    case (c)
      sscp_pkg::CMD_STATUS: return {r.status, 16'h0000};
      sscp_pkg::CMD_TEMP: return r.temp;
      sscp_pkg::CMD_PFILT: return r.pfilt;
      sscp_pkg::CMD_PRAW: return r.praw;
      default: return '0;
    endcase
  endfunction

  function automatic logic [7:0] status_of(input sscp_pkg::sscp_dev_t d);
    case (d)
      sscp_pkg::DEV_IDLE: return sscp_pkg::STAT_IDLE;
      sscp_pkg::DEV_ACTIVE: return sscp_pkg::STAT_ACTIVE;
      default: return sscp_pkg::STAT_SHUT;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link side, clocked by the serial clock

  // store completion and port select into the link domain
  sscp_sync #(.W(2)) u_sync_link (
    .clk(sclk),
    .srst(1'b0),
    .d({co_q.done, iface_sel}),
    .q({done_s, sel_s})
  );

  always_comb begin
    lk_d = lk_q;
    rx_n = {lk_q.rx[6:0], sdi};
    lk_d.rx = rx_n;
    lk_d.bit_idx = lk_q.bit_idx + 3'h1;
    if (lk_q.bit_idx == sscp_pkg::BIT_LAST) begin
      if (lk_q.byte_idx != sscp_pkg::BYTE_MAX) begin
        lk_d.byte_idx = lk_q.byte_idx + 3'h1;
      end
      if (lk_q.byte_idx >= sscp_pkg::BYTE_D0 && lk_q.byte_idx <= sscp_pkg::BYTE_D3) begin
        lk_d.req.coef = {lk_q.req.coef[23:0], rx_n};
      end
      lk_d.tx = sscp_pkg::FILL_BYTE;
      case (lk_q.byte_idx)
        sscp_pkg::BYTE_CMD: begin
          // results are frozen by the core long before this edge
          lk_d.req.cmd = rx_n;
          lk_d.ack_ok = cmd_ok(rx_n, co_q.pub.status);
          lk_d.tx = lk_d.ack_ok ? sscp_pkg::ACK_BYTE : sscp_pkg::NEGATIVE_ACKNOWLEDGE_BYTE;
          lk_d.req.cmd_valid = lk_d.ack_ok && is_ctrl(rx_n) && sel_s;
        end
        sscp_pkg::BYTE_ACK: begin
          lk_d.addr_ok = (rx_n == sscp_pkg::COEF_ADDR);
          lk_d.word = lk_q.ack_ok ? pick(lk_q.req.cmd, co_q.pub) : '0;
          lk_d.tx = lk_d.word[23:16];
        end
        sscp_pkg::BYTE_D0: begin
          lk_d.tx = lk_q.word[15:8];
        end
        sscp_pkg::BYTE_D1: begin
          lk_d.tx = lk_q.word[7:0];
        end
        sscp_pkg::BYTE_D3: begin
          lk_d.req.wr_valid = lk_q.ack_ok && lk_q.addr_ok && sel_s &&
            (lk_q.req.cmd == sscp_pkg::CMD_COEF_WR);
          lk_d.tx = sscp_pkg::BUSY_BYTE;
        end
        default: begin
          if (lk_q.req.wr_valid && done_s) begin
            lk_d.tx = sscp_pkg::DONE_BYTE;
          end else begin
            lk_d.tx = sscp_pkg::BUSY_BYTE;
          end
        end
      endcase
    end
  end

  // sample on rising clock; select high holds everything cleared
  always_ff @(posedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      lk_q <= '0;
    end else begin
      lk_q <= lk_d;
    end
  end

  // drive on falling clock, released as soon as select rises
  always_ff @(negedge sclk or posedge chip_select_low) begin
    if (chip_select_low) begin
      out_q <= '0;
    end else begin
      out_q.sdo <= lk_q.tx[3'h7 - lk_q.bit_idx];
      out_q.oe <= sel_s && (lk_q.byte_idx != sscp_pkg::BYTE_CMD);
    end
  end

  assign sdo = out_q.sdo;
  assign sdo_oe = out_q.oe;

  chk_ack_low: assert property (
    @(posedge sclk) disable iff (chip_select_low)
    (lk_q.byte_idx == sscp_pkg::BYTE_ACK && lk_q.ack_ok) |-> !out_q.sdo)
    else $error("accepted command not answered low");

  chk_negative_acknowledge_high: assert property (
    @(posedge sclk) disable iff (chip_select_low)
    (lk_q.byte_idx == sscp_pkg::BYTE_ACK && !lk_q.ack_ok) |-> out_q.sdo)
    else $error("refused command not answered high");

  chk_sel_release: assert property (
    @(posedge sclk) disable iff (chip_select_low)
    !sel_s |-> !out_q.oe)
    else $error("output driven with port deselected");

  chk_result_msb: assert property (
    @(posedge sclk) disable iff (chip_select_low)
    (lk_q.byte_idx == sscp_pkg::BYTE_D0 && lk_q.bit_idx == 3'h0 && lk_q.ack_ok &&
      lk_q.req.cmd == sscp_pkg::CMD_PFILT)
    |-> (lk_q.tx == lk_q.word[23:16] && lk_q.word == co_q.pub.pfilt))
    else $error("result high byte not sent first");

  chk_poll_byte: assert property (
    @(posedge sclk) disable iff (chip_select_low)
    (lk_q.req.wr_valid && lk_q.bit_idx == 3'h0 && lk_q.byte_idx >= sscp_pkg::BYTE_POLL)
    |-> (lk_q.tx == sscp_pkg::BUSY_BYTE || lk_q.tx == sscp_pkg::DONE_BYTE))
    else $error("poll byte neither busy nor done");

  //////////////////////////////////////////////////////////////////////////
  // core side, clocked by clk

  // frame, command and write levels into the core domain
  sscp_sync #(.W(3)) u_sync_core (
    .clk(clk),
    .srst(srst),
    .d({~chip_select_low, lk_q.req.cmd_valid, lk_q.req.wr_valid}),
    .q({frm_s, cv_s, wv_s})
  );

  assign cmd_rise = cv_s && !co_q.cmd_seen;
  assign wr_rise = wv_s && !co_q.wr_seen;

  // first-order low-pass: y += (x - y) * (1 - coef / 2^27)
  always_comb begin
    diff = $signed({conv_data[23], conv_data}) -
      $signed({co_q.res.pfilt[23], co_q.res.pfilt});
    if (co_q.coef > sscp_pkg::COEF_ONE) begin
      kf = 28'h000_0000;
    end else begin
      kf = 28'(sscp_pkg::COEF_ONE - co_q.coef);
    end
    prod = diff * $signed({1'b0, kf});
    filt_n = co_q.res.pfilt + prod[sscp_pkg::COEF_FRAC +: sscp_pkg::RES_W];
  end

  always_comb begin
    co_d = co_q;
    co_d.conv.start = 1'b0;
    co_d.corr_upd = 1'b0;
    co_d.cmd_seen = cv_s;
    co_d.wr_seen = wv_s;
    // results held still while a frame is in flight
    if (!frm_s) begin
      co_d.pub = co_q.res;
    end
    // done falls once the host has closed the write frame
    if (!wv_s && !co_q.busy) begin
      co_d.done = 1'b0;
    end
    if (wr_rise && co_q.dev == sscp_pkg::DEV_IDLE && !co_q.busy) begin
      co_d.pend = lk_q.req.coef;
      co_d.busy = 1'b1;
      co_d.done = 1'b0;
      co_d.timer = 32'(STORE_CYCLES - 1);
    end else if (co_q.busy) begin
      if (co_q.timer == 32'h0000_0000) begin
        co_d.busy = 1'b0;
        co_d.done = 1'b1;
        co_d.coef = co_q.pend;
      end else begin
        co_d.timer = co_q.timer - 32'h0000_0001;
      end
    end
    if (cmd_rise) begin
      case (lk_q.req.cmd)
        sscp_pkg::CMD_WAKE: begin
          if (co_q.dev == sscp_pkg::DEV_SHUT) begin
            co_d.dev = sscp_pkg::DEV_IDLE;
          end
        end
        sscp_pkg::CMD_START: begin
          if (co_q.dev == sscp_pkg::DEV_IDLE) begin
            co_d.dev = sscp_pkg::DEV_ACTIVE;
          end
        end
        sscp_pkg::CMD_STOP: begin
          if (co_q.dev == sscp_pkg::DEV_ACTIVE) begin
            co_d.dev = sscp_pkg::DEV_IDLE;
          end
        end
        sscp_pkg::CMD_SHUTDOWN: begin
          co_d.dev = sscp_pkg::DEV_SHUT;
          co_d.coef = sscp_pkg::COEF_DEFAULT;
          co_d.busy = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // conversion sequencing
    if (co_q.dev == sscp_pkg::DEV_ACTIVE && !co_q.waiting) begin
      co_d.conv.start = 1'b1;
      co_d.conv.temp = (co_q.pcnt == sscp_pkg::PRES_PER_TEMP);
      co_d.waiting = 1'b1;
    end else if (co_q.waiting && conv_done) begin
      co_d.waiting = 1'b0;
      if (co_q.conv.temp) begin
        co_d.res.temp = conv_data;
        co_d.pcnt = 9'h000;
        co_d.corr_upd = 1'b1;
      end else begin
        co_d.res.praw = conv_data;
        co_d.res.pfilt = filt_n;
        co_d.pcnt = co_q.pcnt + 9'h001;
      end
    end
    co_d.res.status = status_of(co_d.dev);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      co_q <= '0;
      co_q.dev <= sscp_pkg::DEV_SHUT;
      co_q.coef <= sscp_pkg::COEF_DEFAULT;
    end else begin
      co_q <= co_d;
    end
  end

  assign conv_req = co_q.conv;
  assign corr_update = co_q.corr_upd;

  chk_coef_idle: assert property (
    @(posedge clk) disable iff (srst)
    $rose(co_q.busy) |-> ($past(co_q.dev) == sscp_pkg::DEV_IDLE && $past(wv_s)))
    else $error("coefficient store started outside idle");

  chk_shutdown_coef: assert property (
    @(posedge clk) disable iff (srst)
    (co_q.dev != sscp_pkg::DEV_SHUT) ##1 (co_q.dev == sscp_pkg::DEV_SHUT)
    |-> (co_q.coef == sscp_pkg::COEF_DEFAULT && !co_q.busy))
    else $error("shutdown kept a written coefficient");

  chk_temp_every: assert property (
    @(posedge clk) disable iff (srst)
    co_q.conv.start |-> (co_q.conv.temp == (co_q.pcnt == sscp_pkg::PRES_PER_TEMP)))
    else $error("temperature conversion out of turn");

  chk_filter_pass: assert property (
    @(posedge clk) disable iff (srst)
    (co_q.waiting && conv_done && !co_q.conv.temp && co_q.coef == 32'h0000_0000)
    |=> (co_q.res.pfilt == $past(conv_data)))
    else $error("unity filter does not track input");

  chk_store_done: assert property (
    @(posedge clk) disable iff (srst)
    (co_q.busy && co_q.timer == 32'h0000_0000 && !cmd_rise)
    |=> (co_q.done && !co_q.busy && co_q.coef == $past(co_q.pend)))
    else $error("coefficient store did not complete");
endmodule
`default_nettype wire

// ==== sim/sscp_host.sv ====
// host model: serial bus master running clock mode 3 frames
`default_nettype none
module sscp_host (
  // serial link
  output logic sclk,
  output logic chip_select_low,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx [8];
  logic [7:0] rx [128];
  logic line_q;
  logic oe_early;
  logic oe_seen;
  int nrx;
  initial begin
    sclk = 1'b1;
    chip_select_low = 1'b1;
    sdi = 1'b0;
    line_q = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame: ntx bytes sent, nbits clocks; poll keeps clocking until the done byte or 100 bytes
  task automatic frame(input int nbits, input int ntx, input bit poll);
    logic [7:0] sh;
    int i;
    sh = 8'h00;
    oe_early = 1'b0;
    oe_seen = 1'b0;
    nrx = 0;
    i = 0;
    chip_select_low = 1'b0;
    while (i < nbits) begin
      #3 sclk = 1'b0;
      sdi = (i < ntx * 8) ? tx[i / 8][7 - i % 8] : ~sdi;
      #3 sclk = 1'b1;
      // a released line reads as the inverse of its last level
      line_q = sdo_oe ? sdo : ~line_q;
      sh = {sh[6:0], line_q};
      oe_early |= sdo_oe & (i < 8);
      oe_seen |= sdo_oe;
      i++;
      if (i % 8 == 0) begin
        rx[nrx] = sh;
        nrx++;
        if (poll && i == nbits && sh !== 8'h01 && nrx < 100) begin
          nbits += 8;
        end
      end
    end
    #3 chip_select_low = 1'b1;
    #250;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the serial command port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, srst, iface_sel, conv_done, corr_update;
  logic sclk, chip_select_low, sdi, sdo, sdo_oe, is_temp;
  logic [sscp_pkg::RES_W-1:0] conv_data, last_p, last_t, val, filt, d;
  logic [7:0] code;
  sscp_pkg::sscp_conv_t conv_req;
  sscp_pkg::sscp_dev_t st;
  int errors, num_checks, n_ptot, n_pres, n_temp, n_corr, left, k;
  sscp_top #(.STORE_CYCLES(20)) dut (.clk(clk), .srst(srst), .sclk(sclk),
    .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .iface_sel(iface_sel), .conv_req(conv_req), .conv_done(conv_done),
    .conv_data(conv_data), .corr_update(corr_update));
  sscp_host host (.sclk(sclk), .chip_select_low(chip_select_low), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic check_res(input logic [23:0] got, input logic [23:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %b want %b", $time, m, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [7:0] exp_ack(input logic [7:0] c, input sscp_pkg::sscp_dev_t s);
    case (c)
      sscp_pkg::CMD_STATUS, sscp_pkg::CMD_TEMP, sscp_pkg::CMD_PFILT, sscp_pkg::CMD_PRAW,
      sscp_pkg::CMD_WAKE, sscp_pkg::CMD_START, sscp_pkg::CMD_STOP,
      sscp_pkg::CMD_SHUTDOWN: return sscp_pkg::ACK_BYTE;
      sscp_pkg::CMD_COEF_WR: begin
        return (s == sscp_pkg::DEV_IDLE) ? sscp_pkg::ACK_BYTE : sscp_pkg::NEGATIVE_ACKNOWLEDGE_BYTE;
      end
      default: return sscp_pkg::NEGATIVE_ACKNOWLEDGE_BYTE;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // measurement core: answers each start a few cycles later
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (corr_update === 1'b1) n_corr++;
    if (conv_req.start === 1'b1) begin
      check_bit(conv_req.temp, n_pres == 256, "temperature turn");
      is_temp = conv_req.temp;
      left = 2 + $urandom % 4;
    end else if (left > 0) begin
      left--;
      if (left == 0) begin
        d = 24'($urandom);
        conv_data <= d;
        conv_done <= 1'b1;
        if (is_temp) begin
          last_t = d;
          n_temp++;
          n_pres = 0;
        end else begin
          last_p = d;
          n_pres++;
          n_ptot++;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [7:0] c, input int nbits);
    host.tx[0] = c;
    host.frame(nbits, 1, 0);
    check_byte(host.rx[1], exp_ack(c, st), "answer byte");
    check_bit(host.oe_early, 1'b0, "drive during command");
    check_bit(sdo_oe, 1'b0, "drive after frame");
  endtask
  task automatic rd(input logic [7:0] c);
    xfer(c, 40);
    val = {host.rx[2], host.rx[3], host.rx[4]};
  endtask
  task automatic status(input logic [7:0] s);
    xfer(sscp_pkg::CMD_STATUS, 24);
    check_byte(host.rx[2], s, "status");
  endtask
  task automatic wait_pres(input int n);
    for (k = 0; k < 20000 && n_ptot < n; k++) @(posedge clk);
    if (n_ptot < n) begin
      errors++;
      $display("unexpected at %0t: conversions stalled", $time);
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    iface_sel = 1'b1;
    conv_done = 1'b0;
    conv_data = 24'h00_0000;
    st = sscp_pkg::DEV_SHUT;
    void'($urandom(4));
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    status(sscp_pkg::STAT_SHUT);
    for (int j = 0; j < 20; j++) begin
      code = (j < 4) ? 8'hE4 + 8'(j) : 8'($urandom);
      if (code[7:4] == 4'hA && code[1:0] == 2'b00) code ^= 8'h01;
      rd(code);
    end
    @(posedge clk) iface_sel <= 1'b0;
    host.tx[0] = sscp_pkg::CMD_WAKE;
    host.frame(16, 1, 0);
    check_bit(host.oe_seen, 1'b0, "serial port deselected");
    @(posedge clk) iface_sel <= 1'b1;
    status(sscp_pkg::STAT_SHUT);
    xfer(sscp_pkg::CMD_WAKE, 16);
    st = sscp_pkg::DEV_IDLE;
    host.tx[0] = sscp_pkg::CMD_STATUS;
    host.frame(5, 1, 0);
    status(sscp_pkg::STAT_IDLE);
    host.tx[0] = sscp_pkg::CMD_COEF_WR;
    host.tx[1] = sscp_pkg::COEF_ADDR;
    {host.tx[2], host.tx[3], host.tx[4], host.tx[5]} = sscp_pkg::COEF_ONE;
    host.frame(56, 6, 1);
    check_byte(host.rx[1], sscp_pkg::ACK_BYTE, "write answer");
    for (k = 6; k < host.nrx - 1; k++) check_byte(host.rx[k], sscp_pkg::BUSY_BYTE, "busy");
    check_byte(host.rx[host.nrx - 1], sscp_pkg::DONE_BYTE, "done");
    rd(sscp_pkg::CMD_PFILT);
    filt = val;
    xfer(sscp_pkg::CMD_START, 16);
    st = sscp_pkg::DEV_ACTIVE;
    status(sscp_pkg::STAT_ACTIVE);
    xfer(sscp_pkg::CMD_COEF_WR, 16);
    wait_pres(262);
    xfer(sscp_pkg::CMD_STOP, 16);
    st = sscp_pkg::DEV_IDLE;
    repeat (20) @(posedge clk);
    rd(sscp_pkg::CMD_PRAW);
    check_res(val, last_p, "raw pressure");
    rd(sscp_pkg::CMD_TEMP);
    check_res(val, last_t, "temperature");
    rd(sscp_pkg::CMD_PFILT);
    check_res(val, filt, "frozen filter");
    check_byte(8'(n_temp), 8'h01, "temperature count");
    check_byte(8'(n_corr), 8'h01, "correction count");
    xfer(sscp_pkg::CMD_SHUTDOWN, 16);
    st = sscp_pkg::DEV_SHUT;
    status(sscp_pkg::STAT_SHUT);
    xfer(sscp_pkg::CMD_WAKE, 16);
    st = sscp_pkg::DEV_IDLE;
    xfer(sscp_pkg::CMD_START, 16);
    wait_pres(n_ptot + 2);
    xfer(sscp_pkg::CMD_STOP, 16);
    repeat (20) @(posedge clk);
    rd(sscp_pkg::CMD_PFILT);
    check_res(val, last_p, "filter after shutdown");
    final_report();
  end
endmodule
`default_nettype wire
